// ==== src/sag_swell_monitor.sv ====
`timescale 1ns/1ns
`include "vsm_params.svh"
// Operation
// (RULE1) Sag is on while any line voltage is below the sag level but not all are below the interruption level.
// (RULE2) Sag goes off when all voltages are back above the sag level or the maximum time runs out.
// (RULE3) The sag count grows by one only for a sag that ends normally between minimum and maximum time.
// (RULE4) A finished sag reports its duration and lowest values.
// (RULE5) Swell is on while any line voltage is above the swell level.
// (RULE6) Swell goes off when all voltages are below the swell level or the maximum time runs out.
// (RULE7) The swell count grows by one only for a swell that ends normally between minimum and maximum time.
// (RULE8) A finished swell reports its duration and highest values; the code keeps the sag's report instead when a sag finishes in the same cycle.
// (RULE9) Interruption is on only while all three voltages are below the interruption level.
// (RULE10) Interruption goes off when any voltage rises above that level or the maximum time runs out.
// (RULE11) Interruptions are not counted.
// (RULE12) A sag in which not all phases reach the interruption level reports zero for a phase that did.
// (RULE13) Only the latest variation's duration and values are kept.
// (RULE14) On and off changes, count updates and each report raise time-stamped events.
// (RULE15) Separate commands clear the sag count and the swell count, each only its own.
// (RULE16) Durations count whole milliseconds from detection until the output clears.
// (RULE17) A variation shorter than the minimum or cut off by the maximum leaves the count alone.
module sag_swell_monitor #(
    parameter int unsigned TICK_CYCLES = `MS_CYCLES
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire vsm_pkg::volt_t v_ab,
    input  wire vsm_pkg::volt_t v_bc,
    input  wire vsm_pkg::volt_t v_ca,
    output logic              sag,
    output logic              swell,
    output logic              interruption,
    output logic              irq
);
    logic                 tick;
    logic [31:0]          ms_time;
    vsm_pkg::volt_t       v [3];
    logic [2:0]           below_sag;
    logic [2:0]           below_intr;
    logic [2:0]           above_swell;
    logic [2:0]           cond;

    vsm_pkg::volt_t       sag_thr_reg;
    vsm_pkg::volt_t       sag_thr_next;
    vsm_pkg::volt_t       swell_thr_reg;
    vsm_pkg::volt_t       swell_thr_next;
    vsm_pkg::volt_t       intr_thr_reg;
    vsm_pkg::volt_t       intr_thr_next;
    vsm_pkg::ms_t         min_ms_reg;
    vsm_pkg::ms_t         min_ms_next;
    vsm_pkg::ms_t         max_ms_reg;
    vsm_pkg::ms_t         max_ms_next;
    logic [15:0]          sag_cnt_reg;
    logic [15:0]          sag_cnt_next;
    logic [15:0]          swell_cnt_reg;
    logic [15:0]          swell_cnt_next;
    vsm_pkg::ms_t         last_dur_reg;
    vsm_pkg::ms_t         last_dur_next;
    vsm_pkg::volt_t       last_v_reg [3];
    vsm_pkg::volt_t       last_v_next [3];
    vsm_pkg::volt_t       mn_reg [3];
    vsm_pkg::volt_t       mn_next [3];
    vsm_pkg::volt_t       mx_reg [3];
    vsm_pkg::volt_t       mx_next [3];
    logic [`EVT_W-1:0]    evt_reg;
    logic [`EVT_W-1:0]    evt_next;
    logic [`EVT_W-1:0]    evt_set;
    logic [`EVT_W-1:0]    mask_reg;
    logic [`EVT_W-1:0]    mask_next;
    logic [31:0]          evt_time_reg;
    logic [31:0]          evt_time_next;
    logic                 irq_reg;
    logic                 irq_next;
    logic [2:0]           act_d_reg;
    logic [31:0]          prdata_reg;
    logic [31:0]          prdata_next;
    logic                 pready_reg;
    logic                 pready_next;
    logic                 pslverr_reg;
    logic                 pslverr_next;
    logic                 setup;
    logic                 wr;
    logic [31:0]          rdata;
    logic                 unmapped;
    logic                 clr_sag;
    logic                 clr_swell;
    logic [2:0]           act;
    logic [2:0]           done;
    logic [2:0]           qual;
    vsm_pkg::ms_t         dur [3];
    logic                 sag_inc;
    logic                 swell_inc;

    tmr_if t_if [3] ();

    ms_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (tick),
        .ms_time (ms_time)
    );

    assign v[0] = v_ab;
    assign v[1] = v_bc;
    assign v[2] = v_ca;

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_ph
            assign below_sag[g]   = (v[g] < sag_thr_reg);
            assign below_intr[g]  = (v[g] < intr_thr_reg);
            assign above_swell[g] = (v[g] > swell_thr_reg);
            assign t_if[g].cond   = cond[g];
            assign t_if[g].tick   = tick;
            assign t_if[g].min_ms = min_ms_reg;
            assign t_if[g].max_ms = max_ms_reg;
            assign act[g]         = t_if[g].active;
            assign done[g]        = t_if[g].done;
            assign qual[g]        = t_if[g].qual;
            assign dur[g]         = t_if[g].dur;
            cond_timer u_tmr (
                .sys_clk (sys_clk),
                .rst     (rst),
                .t       (t_if[g])
            );
        end
    endgenerate

    // A phase under the interruption level still counts as sag unless all are under it.
    assign cond[`C_SAG]   = (|below_sag) && !(&below_intr); // RULE1 RULE12
    assign cond[`C_SWELL] = |above_swell; // RULE5
    assign cond[`C_INTR]  = &below_intr; // RULE9

    assign setup = psel && !penable;
    assign wr    = psel && penable && pready_reg && pwrite && (paddr[31:8] == 24'h00_0000);
    assign clr_sag   = wr && (paddr[7:0] == `A_CMD) && pwdata[`CMD_CLR_SAG];
    assign clr_swell = wr && (paddr[7:0] == `A_CMD) && pwdata[`CMD_CLR_SWELL];
    // A variation that runs straight into another condition has not returned to normal.
    assign sag_inc   = done[`C_SAG] && qual[`C_SAG] && !act[`C_SWELL] && !act[`C_INTR]; // RULE3
    assign swell_inc = done[`C_SWELL] && qual[`C_SWELL] && !act[`C_SAG] && !act[`C_INTR]; // RULE7

    always_comb
    begin
        unmapped = 1'b0;
        rdata    = 32'h0000_0000;
        unique case (paddr[7:0])
            `A_SAG_THR:   rdata[15:0] = sag_thr_reg;
            `A_SWELL_THR: rdata[15:0] = swell_thr_reg;
            `A_INTR_THR:  rdata[15:0] = intr_thr_reg;
            `A_MIN_MS:    rdata[15:0] = min_ms_reg;
            `A_MAX_MS:    rdata[15:0] = max_ms_reg;
            `A_CMD:       rdata       = 32'h0000_0000;
            `A_STATUS:    rdata[2:0]  = act;
            `A_SAG_CNT:   rdata[15:0] = sag_cnt_reg;
            `A_SWELL_CNT: rdata[15:0] = swell_cnt_reg;
            `A_LAST_DUR:  rdata[15:0] = last_dur_reg;
            `A_LAST_V1:   rdata[15:0] = last_v_reg[0];
            `A_LAST_V2:   rdata[15:0] = last_v_reg[1];
            `A_LAST_V3:   rdata[15:0] = last_v_reg[2];
            `A_EVT:       rdata[`EVT_W-1:0] = evt_reg;
            `A_EVT_MASK:  rdata[`EVT_W-1:0] = mask_reg;
            `A_EVT_TIME:  rdata       = evt_time_reg;
            `A_MS_TIME:   rdata       = ms_time;
            default:      unmapped    = 1'b1;
        endcase
        if (paddr[31:8] != 24'h00_0000)
        begin
            unmapped = 1'b1;
            rdata    = 32'h0000_0000;
        end
    end

    always_comb
    begin
        pready_next    = setup;
        prdata_next    = setup ? rdata : 32'h0000_0000;
        pslverr_next   = setup && unmapped;
        sag_thr_next   = sag_thr_reg;
        swell_thr_next = swell_thr_reg;
        intr_thr_next  = intr_thr_reg;
        min_ms_next    = min_ms_reg;
        max_ms_next    = max_ms_reg;
        mask_next      = mask_reg;
        if (wr)
        begin
            unique case (paddr[7:0])
                `A_SAG_THR:   sag_thr_next   = pwdata[15:0];
                `A_SWELL_THR: swell_thr_next = pwdata[15:0];
                `A_INTR_THR:  intr_thr_next  = pwdata[15:0];
                `A_MIN_MS:    min_ms_next    = pwdata[15:0];
                `A_MAX_MS:    max_ms_next    = pwdata[15:0];
                `A_EVT_MASK:  mask_next      = pwdata[`EVT_W-1:0];
                default:      mask_next      = mask_reg;
            endcase
        end
    end

    // Extremes follow the live value while quiet and track the running minimum and maximum while a variation runs.
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            if (|cond || |act)
            begin
                mn_next[p] = (v[p] < mn_reg[p]) ? v[p] : mn_reg[p];
                mx_next[p] = (v[p] > mx_reg[p]) ? v[p] : mx_reg[p];
            end
            else
            begin
                mn_next[p] = v[p];
                mx_next[p] = v[p];
            end
        end
    end

    always_comb
    begin
        // A clear and an increment in one cycle leave the count at one.
        sag_cnt_next   = (clr_sag ? 16'h0000 : sag_cnt_reg)
                       + {15'h0000, sag_inc}; // RULE3 RULE15 RULE17
        swell_cnt_next = (clr_swell ? 16'h0000 : swell_cnt_reg)
                       + {15'h0000, swell_inc}; // RULE7 RULE15 RULE17
        last_dur_next  = last_dur_reg;
        for (int p = 0; p < 3; p++)
        begin
            last_v_next[p] = last_v_reg[p];
        end
        if (done[`C_INTR])
        begin
            last_dur_next = dur[`C_INTR]; // RULE13 RULE11
            for (int p = 0; p < 3; p++)
            begin
                last_v_next[p] = mn_reg[p];
            end
        end
        else if (done[`C_SAG])
        begin
            last_dur_next = dur[`C_SAG]; // RULE4 RULE13
            for (int p = 0; p < 3; p++)
            begin
                last_v_next[p] = (mn_reg[p] < intr_thr_reg) ? 16'h0000 : mn_reg[p]; // RULE12
            end
        end
        else if (done[`C_SWELL])
        begin
            last_dur_next = dur[`C_SWELL]; // RULE8 RULE13
            for (int p = 0; p < 3; p++)
            begin
                last_v_next[p] = mx_reg[p];
            end
        end
    end

    always_comb
    begin
        evt_set = '0;
        evt_set[`EV_SAG_ON]    = act[`C_SAG] && !act_d_reg[`C_SAG]; // RULE14
        evt_set[`EV_SAG_OFF]   = !act[`C_SAG] && act_d_reg[`C_SAG];
        evt_set[`EV_SWELL_ON]  = act[`C_SWELL] && !act_d_reg[`C_SWELL];
        evt_set[`EV_SWELL_OFF] = !act[`C_SWELL] && act_d_reg[`C_SWELL];
        evt_set[`EV_INTR_ON]   = act[`C_INTR] && !act_d_reg[`C_INTR];
        evt_set[`EV_INTR_OFF]  = !act[`C_INTR] && act_d_reg[`C_INTR];
        evt_set[`EV_SAG_CNT]   = clr_sag || sag_inc;
        evt_set[`EV_SWELL_CNT] = clr_swell || swell_inc;
        evt_set[`EV_REPORT]    = |done;
        // Write one to clear; a new event in the same cycle still sets.
        evt_next = evt_reg;
        if (wr && (paddr[7:0] == `A_EVT))
        begin
            evt_next = evt_reg & ~pwdata[`EVT_W-1:0];
        end
        evt_next      = evt_next | evt_set;
        evt_time_next = (|evt_set) ? ms_time : evt_time_reg; // RULE14
        irq_next      = |(evt_next & mask_next);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sag_thr_reg   <= `RST_SAG_THR;
            swell_thr_reg <= `RST_SWELL_THR;
            intr_thr_reg  <= `RST_INTR_THR;
            min_ms_reg    <= `RST_MIN_MS;
            max_ms_reg    <= `RST_MAX_MS;
            sag_cnt_reg   <= 16'h0000;
            swell_cnt_reg <= 16'h0000;
            last_dur_reg  <= 16'h0000;
            evt_reg       <= '0;
            mask_reg      <= '0;
            evt_time_reg  <= 32'h0000_0000;
            irq_reg       <= 1'b0;
            act_d_reg     <= 3'h0;
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            for (int p = 0; p < 3; p++)
            begin
                last_v_reg[p] <= 16'h0000;
                mn_reg[p]     <= 16'h0000;
                mx_reg[p]     <= 16'h0000;
            end
        end
        else
        begin
            sag_thr_reg   <= sag_thr_next;
            swell_thr_reg <= swell_thr_next;
            intr_thr_reg  <= intr_thr_next;
            min_ms_reg    <= min_ms_next;
            max_ms_reg    <= max_ms_next;
            sag_cnt_reg   <= sag_cnt_next;
            swell_cnt_reg <= swell_cnt_next;
            last_dur_reg  <= last_dur_next;
            evt_reg       <= evt_next;
            mask_reg      <= mask_next;
            evt_time_reg  <= evt_time_next;
            irq_reg       <= irq_next;
            act_d_reg     <= act;
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            for (int p = 0; p < 3; p++)
            begin
                last_v_reg[p] <= last_v_next[p];
                mn_reg[p]     <= mn_next[p];
                mx_reg[p]     <= mx_next[p];
            end
        end
    end

    assign sag          = act[`C_SAG]; // RULE2
    assign swell        = act[`C_SWELL]; // RULE6
    assign interruption = act[`C_INTR]; // RULE10
    assign irq          = irq_reg;
    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
endmodule

// ==== src/vsm_params.svh ====
`ifndef VSM_PARAMS_SVH
`define VSM_PARAMS_SVH

`define CLK_PERIOD_NS   50
`define MS_PERIOD_NS    1000000
`define MS_CYCLES       (`MS_PERIOD_NS / `CLK_PERIOD_NS)

`define VOLT_W          16
`define EVT_W           9

`define A_SAG_THR       8'h00
`define A_SWELL_THR     8'h04
`define A_INTR_THR      8'h08
`define A_MIN_MS        8'h0c
`define A_MAX_MS        8'h10
`define A_CMD           8'h14
`define A_STATUS        8'h18
`define A_SAG_CNT       8'h1c
`define A_SWELL_CNT     8'h20
`define A_LAST_DUR      8'h24
`define A_LAST_V1       8'h28
`define A_LAST_V2       8'h2c
`define A_LAST_V3       8'h30
`define A_EVT           8'h34
`define A_EVT_MASK      8'h38
`define A_EVT_TIME      8'h3c
`define A_MS_TIME       8'h40

`define RST_SAG_THR     16'h0000
`define RST_SWELL_THR   16'hffff
`define RST_INTR_THR    16'h0000
`define RST_MIN_MS      16'h0000
`define RST_MAX_MS      16'hffff

`define CMD_CLR_SAG     0
`define CMD_CLR_SWELL   1

`define EV_SAG_ON       0
`define EV_SAG_OFF      1
`define EV_SWELL_ON     2
`define EV_SWELL_OFF    3
`define EV_INTR_ON      4
`define EV_INTR_OFF     5
`define EV_SAG_CNT      6
`define EV_SWELL_CNT    7
`define EV_REPORT       8

`define C_SAG           0
`define C_SWELL         1
`define C_INTR          2

`endif

// ==== src/vsm_pkg.sv ====
package vsm_pkg;
    typedef enum logic [1:0] {T_IDLE, T_RUN, T_HOLD} tmr_state_e;
    typedef logic [15:0] volt_t;
    typedef logic [15:0] ms_t;
endpackage

// ==== src/tmr_if.sv ====
`timescale 1ns/1ns
interface tmr_if;
    logic          cond;
    logic          tick;
    vsm_pkg::ms_t  min_ms;
    vsm_pkg::ms_t  max_ms;
    logic          active;
    vsm_pkg::ms_t  dur;
    logic          done;
    logic          qual;
    modport timer (input cond, input tick, input min_ms, input max_ms,
                   output active, output dur, output done, output qual);
    modport owner (output cond, output tick, output min_ms, output max_ms,
                   input active, input dur, input done, input qual);
endinterface

// ==== src/ms_tick.sv ====
`timescale 1ns/1ns
`include "vsm_params.svh"
module ms_tick #(
    parameter int unsigned TICK_CYCLES = `MS_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    output logic             tick,
    output logic [31:0]      ms_time
);
    logic [31:0] div_reg;
    logic [31:0] div_next;
    logic        tick_reg;
    logic        tick_next;
    logic [31:0] ms_reg;
    logic [31:0] ms_next;

    always_comb
    begin
        tick_next = (div_reg == TICK_CYCLES - 1);
        div_next  = tick_next ? 32'h0000_0000 : div_reg + 32'h0000_0001;
        ms_next   = tick_next ? ms_reg + 32'h0000_0001 : ms_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            div_reg  <= 32'h0000_0000;
            tick_reg <= 1'b0;
            ms_reg   <= 32'h0000_0000;
        end
        else
        begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
            ms_reg   <= ms_next;
        end
    end

    assign tick    = tick_reg;
    assign ms_time = ms_reg;
endmodule

// ==== src/cond_timer.sv ====
`timescale 1ns/1ns
module cond_timer (
    input  wire logic sys_clk,
    input  wire logic rst,
    tmr_if.timer      t
);
    vsm_pkg::tmr_state_e state_reg;
    vsm_pkg::tmr_state_e state_next;
    vsm_pkg::ms_t        dur_reg;
    vsm_pkg::ms_t        dur_next;
    vsm_pkg::ms_t        dur_inc;
    logic                active_reg;
    logic                active_next;
    logic                done_reg;
    logic                done_next;
    logic                qual_reg;
    logic                qual_next;

    always_comb
    begin
        state_next  = state_reg;
        dur_next    = dur_reg;
        active_next = active_reg;
        done_next   = 1'b0;
        qual_next   = 1'b0;
        dur_inc     = dur_reg + 16'h0001;
        unique case (state_reg)
            vsm_pkg::T_IDLE:
                if (t.cond)
                begin
                    state_next  = vsm_pkg::T_RUN;
                    active_next = 1'b1;
                    dur_next    = 16'h0000; // RULE16
                end
            vsm_pkg::T_RUN:
                if (!t.cond)
                begin
                    state_next  = vsm_pkg::T_IDLE;
                    active_next = 1'b0;
                    done_next   = 1'b1;
                    qual_next   = (dur_reg >= t.min_ms); // RULE17
                end
                else if (t.tick)
                begin
                    dur_next = dur_inc; // RULE16
                    if (dur_inc >= t.max_ms)
                    begin
                        // Expiry ends the output but waits for the condition to go.
                        state_next  = vsm_pkg::T_HOLD;
                        active_next = 1'b0;
                        done_next   = 1'b1;
                    end
                end
            vsm_pkg::T_HOLD:
                if (!t.cond)
                begin
                    state_next = vsm_pkg::T_IDLE;
                end
            default:
                state_next = vsm_pkg::T_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg  <= vsm_pkg::T_IDLE;
            dur_reg    <= 16'h0000;
            active_reg <= 1'b0;
            done_reg   <= 1'b0;
            qual_reg   <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            dur_reg    <= dur_next;
            active_reg <= active_next;
            done_reg   <= done_next;
            qual_reg   <= qual_next;
        end
    end

    assign t.active = active_reg;
    assign t.dur    = dur_reg;
    assign t.done   = done_reg;
    assign t.qual   = qual_reg;
endmodule

// ==== test/vsm_properties.sv ====
`timescale 1ns/1ns
module vsm_properties (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sag,
    input wire logic        swell,
    input wire logic        interruption,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_answer;
        s_setup |=> s_access;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_cause;
        pready |-> $past(psel && !penable);
    endproperty
    property p_err_hi;
        s_setup ##0 (paddr[31:8] != 24'h00_0000) |=> pslverr;
    endproperty
    property p_err_lo;
        s_setup ##0 (paddr <= 32'h0000_0040 && paddr[1:0] == 2'b00) |=> !pslverr;
    endproperty
    property p_err_only;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    property p_excl;
        !(sag && interruption);
    endproperty
    property p_rst_out;
        $fell(rst) |-> !sag && !swell && !interruption && !irq && !pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no access answer");
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    a_cause: assert property (p_cause) else $error("pready without setup");
    a_err_hi: assert property (p_err_hi) else $error("no error for high address");
    a_err_lo: assert property (p_err_lo) else $error("error on mapped address");
    a_err_only: assert property (p_err_only) else $error("bad error response");
    a_excl: assert property (p_excl) else $error("sag with interruption");
    a_rst_out: assert property (p_rst_out) else $error("outputs set after reset");
endmodule

bind sag_swell_monitor vsm_properties u_props (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sag(sag), .swell(swell), .interruption(interruption), .irq(irq));

// ==== test/rms_front_end.sv ====
`timescale 1ns/1ns
module rms_front_end (
    input  wire logic     sys_clk,
    output vsm_pkg::volt_t v_ab,
    output vsm_pkg::volt_t v_bc,
    output vsm_pkg::volt_t v_ca
);
    initial
    begin
        v_ab = 16'h0000;
        v_bc = 16'h0000;
        v_ca = 16'h0000;
    end
    // New RMS values appear just after an edge and hold until the next update.
    task automatic apply(input vsm_pkg::volt_t a, input vsm_pkg::volt_t b, input vsm_pkg::volt_t c);
        @(posedge sys_clk);
        v_ab <= a;
        v_bc <= b;
        v_ca <= c;
    endtask
endmodule

// ==== test/test_voltage_sag_swell_monitor.sv ====
`timescale 1ns/1ns
`include "vsm_params.svh"
module test_voltage_sag_swell_monitor;
    typedef struct {
        logic [15:0] a, b, c;
        int          hold;
        logic [31:0] st, ns, nw, last;
    } row_s;
    row_s           rows [6] = '{
        '{16'h005a, 16'h0096, 16'h0096, 20, 1, 1, 0, 16'h005a},
        '{16'h00d2, 16'h0096, 16'h0096, 20, 2, 1, 1, 16'h00d2},
        '{16'h000a, 16'h000a, 16'h000a, 20, 4, 1, 1, 16'h000a},
        '{16'h000a, 16'h000a, 16'h0096, 20, 1, 2, 1, 16'h0000},
        '{16'h0096, 16'h005f, 16'h0096, 2, 1, 2, 1, 16'h0096},
        '{16'h0096, 16'h0096, 16'h00e6, 20, 2, 2, 2, 16'h0096}
    };
    logic           sys_clk = 0;
    logic           rst = 1;
    logic           psel = 0;
    logic           penable = 0;
    logic           pwrite = 0;
    logic [31:0]    paddr = 0;
    logic [31:0]    pwdata = 0;
    logic [31:0]    prdata, q, t_ms;
    logic           pready, pslverr, e, sag, swell, interruption, irq;
    vsm_pkg::volt_t v_ab, v_bc, v_ca;
    int             num_errors = 0;
    int             n_tests = 0;

    sag_swell_monitor #(.TICK_CYCLES(4)) uut (.sys_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .v_ab, .v_bc, .v_ca, .sag, .swell,
        .interruption, .irq);
    rms_front_end fe (.sys_clk, .v_ab, .v_bc, .v_ca);

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 50)
            num_errors++;
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        check(q, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic wrap_up;
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #(5000 * 50);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        cyc(10);
        rst <= 0;
        rd(`A_SWELL_THR, 32'h0000_ffff);
        rd(`A_MAX_MS, 32'h0000_ffff);
        rd(`A_STATUS, 32'h0000_0000);
        apb(0, 32'h0000_0100, 0);
        check(e, 1);
        apb(0, 32'h0000_0080, 0);
        check(e, 1);
        apb(1, `A_SAG_THR, 32'h0000_0064);
        apb(1, `A_SWELL_THR, 32'h0000_00c8);
        apb(1, `A_INTR_THR, 32'h0000_0014);
        apb(1, `A_MIN_MS, 32'h0000_0003);
        apb(1, `A_MAX_MS, 32'h0000_000a);
        fe.apply(16'h0096, 16'h0096, 16'h0096);
        cyc(4);
        foreach (rows[i])
        begin
            fe.apply(rows[i].a, rows[i].b, rows[i].c);
            rd(`A_STATUS, rows[i].st);
            check({29'h0000_0000, interruption, swell, sag}, rows[i].st);
            cyc(rows[i].hold);
            fe.apply(16'h0096, 16'h0096, 16'h0096);
            cyc(6);
            rd(`A_STATUS, 32'h0000_0000);
            check({29'h0000_0000, interruption, swell, sag}, 32'h0000_0000);
            rd(`A_SAG_CNT, rows[i].ns);
            rd(`A_SWELL_CNT, rows[i].nw);
            rd(`A_LAST_V1, rows[i].last);
            apb(0, `A_LAST_DUR, 0);
            if (rows[i].hold > 4)
                check(q >= 5 && q <= 7, 1);
        end
        apb(1, `A_EVT, 32'h0000_01ff);
        apb(1, `A_EVT_MASK, 32'h0000_0000);
        fe.apply(16'h005a, 16'h0096, 16'h0096);
        cyc(3);
        check(irq, 0);
        rd(`A_EVT, 32'h0000_0001);
        apb(1, `A_EVT_MASK, 32'h0000_0001);
        cyc(2);
        check(irq, 1);
        apb(1, `A_EVT, 32'h0000_0001);
        cyc(2);
        check(irq, 0);
        cyc(45);
        rd(`A_STATUS, 32'h0000_0000);
        apb(0, `A_EVT, 0);
        check(q & 32'h0000_0002, 32'h0000_0002);
        fe.apply(16'h0096, 16'h0096, 16'h0096);
        cyc(6);
        rd(`A_SAG_CNT, 32'h0000_0002);
        apb(0, `A_MS_TIME, 0);
        t_ms = q;
        apb(0, `A_EVT_TIME, 0);
        check(q <= t_ms && q + 20 >= t_ms, 1);
        apb(1, `A_CMD, 32'h0000_0001);
        rd(`A_SAG_CNT, 32'h0000_0000);
        rd(`A_SWELL_CNT, 32'h0000_0002);
        apb(1, `A_CMD, 32'h0000_0002);
        rd(`A_SWELL_CNT, 32'h0000_0000);
        rd(`A_CMD, 32'h0000_0000);
        fe.apply(16'h005a, 16'h0096, 16'h0096);
        cyc(3);
        check(sag, 1);
        rst <= 1;
        cyc(2);
        rst <= 0;
        check({29'h0000_0000, interruption, swell, sag}, 32'h0000_0000);
        rd(`A_SAG_THR, 32'h0000_0000);
        rd(`A_STATUS, 32'h0000_0000);
        wrap_up();
    end
endmodule
